// ===== design/pdr_defs.svh
// Register offsets, field positions and reset values of the interrupt and diagnostic register bank
`ifndef PDR_DEFS_SVH
`define PDR_DEFS_SVH
`define PDR_ADDR_INT_CS 5'h1b
`define PDR_ADDR_DIAG 5'h1d
`define PDR_ADDR_CTRL1 5'h1e
`define PDR_ADDR_CTRL2 5'h1f
`define PDR_INT_LINKUP_EN_BIT 8
`define PDR_DIAG_START_BIT 15
`define PDR_CTRL2_INT_LEVEL_BIT 9
`define PDR_INT_EN_RESET 8'h00
`define PDR_INT_FLAGS_RESET 8'h00
`define PDR_DIAG_RESULT_RESET 2'h0
`define PDR_DIST_RESET 9'h000
`define PDR_SHORT_RESET 1'b0
`define PDR_INT_LEVEL_RESET 1'b0
`define PDR_CTRL1_RESET 3'h0
`define PDR_RDATA_RESET 16'h0000
`endif

// ===== design/pdr_pkg.sv
// Types shared by the register bank and its flag module
`default_nettype none
package pdr_pkg;
  // Event pulses, bit order matches the flag field of the interrupt register
  typedef struct packed {
    logic jabber;
    logic rx_error;
    logic page_rx;
    logic par_det_fault;
    logic lp_ack;
    logic link_down;
    logic remote_fault;
    logic link_up;
  } pdr_events_t;
  // Result handed over by the cable test engine
  typedef struct packed {
    logic [1:0] result;
    logic short_cable;
    logic [8:0] distance;
  } pdr_diag_t;
  typedef enum logic [1:0] {
    PDR_DIAG_NORMAL = 2'h0,
    PDR_DIAG_OPEN = 2'h1,
    PDR_DIAG_SHORT = 2'h2,
    PDR_DIAG_FAIL = 2'h3
  } pdr_diag_code_t;
  typedef enum logic [1:0] {
    PDR_IDLE = 2'h0,
    PDR_RUN = 2'h1,
    PDR_DONE = 2'h3
  } pdr_diag_state_t;
endpackage
`default_nettype wire

// ===== design/pdr_flags.sv
// Sticky event flags that clear when the register holding them is read
`default_nettype none
`include "pdr_defs.svh"
module pdr_flags
  import pdr_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire pdr_events_t i_events,
  input wire logic i_read_clear,
  output logic [7:0] o_flags
);
  logic [7:0] flags_reg;
  logic [7:0] flags_next;

  // An event arriving in the read cycle survives for the next read
  always_comb
  begin
    flags_next = i_events | (i_read_clear ? 8'h00 : flags_reg);
  end

  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
      flags_reg <= `PDR_INT_FLAGS_RESET;
    else
      flags_reg <= flags_next;
  end

  assign o_flags = flags_reg;

  a_flag_set_sticky: assert property (@(posedge i_clock) disable iff (i_rst)
    (i_events != 8'h00) |=> ((o_flags & $past(i_events)) == $past(i_events)))
    else $error("event did not latch");
  a_flag_clear_read: assert property (@(posedge i_clock) disable iff (i_rst)
    (i_read_clear && i_events == 8'h00) |=> (o_flags == 8'h00))
    else $error("flags not cleared by read");
endmodule
`default_nettype wire

// ===== design/pdr_regs.sv
// Interrupt, cable diagnostic and control register bank on the management register port
`default_nettype none
`include "pdr_defs.svh"
module pdr_regs
  import pdr_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic [4:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [15:0] i_reg_wdata,
  output logic [15:0] o_reg_rdata,
  input wire pdr_events_t i_events,
  input wire logic i_diag_done,
  input wire pdr_diag_t i_diag,
  input wire logic i_pause_capable,
  input wire logic i_link_up,
  input wire logic i_polarity_reversed,
  output logic o_diag_start,
  output logic o_int_pin
);
  logic [7:0] int_en_reg;
  logic int_level_reg;
  logic diag_busy_reg;
  pdr_diag_state_t diag_state_reg;
  pdr_diag_t diag_reg;
  logic [2:0] ctrl1_reg;
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;
  logic [7:0] flags;
  logic read_int;
  logic int_active;

  function automatic logic hit(input logic [4:0] addr, input logic [4:0] target);
    hit = (addr == target);
  endfunction

  assign read_int = i_reg_rd && hit(i_reg_addr, `PDR_ADDR_INT_CS);

  pdr_flags u_flags (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_events(i_events),
    .i_read_clear(read_int),
    .o_flags(flags)
  );

  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
      int_en_reg <= `PDR_INT_EN_RESET;
    else if (i_reg_wr && hit(i_reg_addr, `PDR_ADDR_INT_CS))
      int_en_reg <= i_reg_wdata[15:8];
  end

  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
      int_level_reg <= `PDR_INT_LEVEL_RESET;
    else if (i_reg_wr && hit(i_reg_addr, `PDR_ADDR_CTRL2))
      int_level_reg <= i_reg_wdata[`PDR_CTRL2_INT_LEVEL_BIT];
  end

  // Start requests during a running test are ignored so results never mix
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      diag_state_reg <= PDR_IDLE;
      diag_busy_reg <= 1'b0;
      diag_reg <= {`PDR_DIAG_RESULT_RESET, `PDR_SHORT_RESET, `PDR_DIST_RESET};
    end
    else
    begin
      case (diag_state_reg)
        PDR_IDLE, PDR_DONE:
        begin
          if (i_reg_wr && hit(i_reg_addr, `PDR_ADDR_DIAG) && i_reg_wdata[`PDR_DIAG_START_BIT])
          begin
            diag_state_reg <= PDR_RUN;
            diag_busy_reg <= 1'b1;
          end
        end
        PDR_RUN:
        begin
          if (i_diag_done)
          begin
            diag_state_reg <= PDR_DONE;
            diag_busy_reg <= 1'b0;
            diag_reg <= i_diag;
          end
        end
        default:
        begin
          diag_state_reg <= PDR_IDLE;
          diag_busy_reg <= 1'b0;
        end
      endcase
    end
  end

  assign o_diag_start = diag_busy_reg;

  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
      ctrl1_reg <= `PDR_CTRL1_RESET;
    else
      ctrl1_reg <= {i_pause_capable, i_link_up, i_polarity_reversed};
  end

  always_comb
  begin
    rdata_next = 16'h0000;
    case (i_reg_addr)
      `PDR_ADDR_INT_CS: rdata_next = {int_en_reg, flags};
      `PDR_ADDR_DIAG: rdata_next = {diag_busy_reg, diag_reg.result, diag_reg.short_cable, 3'h0, diag_reg.distance};
      `PDR_ADDR_CTRL1: rdata_next = {6'h00, ctrl1_reg, 7'h00};
      `PDR_ADDR_CTRL2: rdata_next = {6'h00, int_level_reg, 9'h000};
      default: rdata_next = 16'h0000;
    endcase
  end

  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
      rdata_reg <= `PDR_RDATA_RESET;
    else if (i_reg_rd)
      rdata_reg <= rdata_next;
  end

  assign o_reg_rdata = rdata_reg;

  // Level follows the flags, so a read of the register deasserts the pin one cycle later
  assign int_active = |(flags & int_en_reg);
  assign o_int_pin = int_level_reg ? int_active : ~int_active;

  sequence s_start_write;
    i_reg_wr && hit(i_reg_addr, `PDR_ADDR_DIAG) && i_reg_wdata[`PDR_DIAG_START_BIT] && !diag_busy_reg;
  endsequence
  sequence s_done;
    diag_busy_reg && i_diag_done;
  endsequence
  sequence s_diag_read;
    i_reg_rd && hit(i_reg_addr, `PDR_ADDR_DIAG);
  endsequence

  a_diag_start_sets: assert property (@(posedge i_clock) disable iff (i_rst)
    s_start_write |=> o_diag_start)
    else $error("start bit not set by write");
  a_diag_self_clear: assert property (@(posedge i_clock) disable iff (i_rst)
    s_done |=> !o_diag_start && diag_reg == $past(i_diag))
    else $error("start bit not cleared with result");
  a_diag_result_hold: assert property (@(posedge i_clock) disable iff (i_rst)
    !diag_busy_reg |=> $stable(diag_reg))
    else $error("result changed while idle");
  a_int_pin_level: assert property (@(posedge i_clock) disable iff (i_rst)
    o_int_pin == (int_level_reg ~^ (|(flags & int_en_reg))))
    else $error("interrupt pin wrong");
  a_en_write: assert property (@(posedge i_clock) disable iff (i_rst)
    (i_reg_wr && i_reg_addr == `PDR_ADDR_INT_CS) |=> int_en_reg == $past(i_reg_wdata[15:8]))
    else $error("enable write lost");
  a_status_track: assert property (@(posedge i_clock) disable iff (i_rst)
    1'b1 |=> ctrl1_reg[1] == $past(i_link_up))
    else $error("link status not tracked");
  a_read_data: assert property (@(posedge i_clock) disable iff (i_rst)
    (i_reg_rd && i_reg_addr == `PDR_ADDR_CTRL1) |=> o_reg_rdata[9:7] == $past(ctrl1_reg))
    else $error("control one read wrong");
  a_flag_read_back: assert property (@(posedge i_clock) disable iff (i_rst)
    read_int |=> o_reg_rdata[7:0] == $past(flags))
    else $error("flag read wrong");
  // A test in progress only ends on the engine's done pulse
  a_diag_busy_hold: assert property (@(posedge i_clock) disable iff (i_rst)
    (diag_busy_reg && !i_diag_done) |=> o_diag_start)
    else $error("test stopped before done");
  a_diag_result_run: assert property (@(posedge i_clock) disable iff (i_rst)
    (diag_busy_reg && !i_diag_done) |=> $stable(diag_reg))
    else $error("result changed while test runs");
  a_diag_read_start: assert property (@(posedge i_clock) disable iff (i_rst)
    s_diag_read |=> o_reg_rdata[15] == $past(diag_busy_reg))
    else $error("start bit read wrong");
  a_diag_read_code: assert property (@(posedge i_clock) disable iff (i_rst)
    s_diag_read |=> o_reg_rdata[14:13] == $past(diag_reg.result))
    else $error("result code read wrong");
  a_diag_read_short: assert property (@(posedge i_clock) disable iff (i_rst)
    s_diag_read |=> o_reg_rdata[12] == $past(diag_reg.short_cable))
    else $error("short cable bit read wrong");
  a_diag_read_dist: assert property (@(posedge i_clock) disable iff (i_rst)
    s_diag_read |=> o_reg_rdata[11:0] == {3'h0, $past(diag_reg.distance)})
    else $error("fault distance read wrong");
  a_level_write: assert property (@(posedge i_clock) disable iff (i_rst)
    (i_reg_wr && i_reg_addr == `PDR_ADDR_CTRL2) |=> int_level_reg == $past(i_reg_wdata[`PDR_CTRL2_INT_LEVEL_BIT]))
    else $error("interrupt level write lost");
  a_int_raise: assert property (@(posedge i_clock) disable iff (i_rst)
    ((|(i_events & int_en_reg)) && !(i_reg_wr && i_reg_addr == `PDR_ADDR_INT_CS)) |=> int_active)
    else $error("enabled event raised no interrupt");
  a_int_drop_read: assert property (@(posedge i_clock) disable iff (i_rst)
    (read_int && i_events == 8'h00) |=> !int_active)
    else $error("interrupt stayed after read");
  a_polarity_track: assert property (@(posedge i_clock) disable iff (i_rst)
    1'b1 |=> ctrl1_reg[0] == $past(i_polarity_reversed))
    else $error("polarity status not tracked");
  a_ctrl1_reserved: assert property (@(posedge i_clock) disable iff (i_rst)
    (i_reg_rd && i_reg_addr == `PDR_ADDR_CTRL1) |=> o_reg_rdata[15:10] == 6'h00 && o_reg_rdata[6:0] == 7'h00)
    else $error("control one reserved bits set");
  // Read data must stand until the next read so a slow controller can take it
  a_rdata_hold: assert property (@(posedge i_clock) disable iff (i_rst)
    !i_reg_rd |=> $stable(o_reg_rdata))
    else $error("read data changed without read");
endmodule
`default_nettype wire

// ===== verification/pdr_diag_model.sv
// Model of the external cable test engine answering a start request
`default_nettype none
module pdr_diag_model
  import pdr_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_start,
  input wire pdr_diag_t i_plan,
  output logic o_done,
  output pdr_diag_t o_diag
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] cnt_reg;
  // Result is valid only with done; inverted otherwise so a stale sample shows
  assign o_diag = o_done ? i_plan : ~i_plan;
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      cnt_reg <= 6'h00;
      o_done <= 1'b0;
    end
    else
    begin
      o_done <= (cnt_reg == 6'h14);
      cnt_reg <= (i_start && cnt_reg != 6'h14 && !o_done) ? cnt_reg + 6'h01 : 6'h00;
    end
  end
endmodule
`default_nettype wire

// ===== verification/pdr_regs_tb_top.sv
// Self-checking bench for the interrupt and cable diagnostic register bank
`default_nettype none
module pdr_regs_tb_top
  import pdr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clock = 1'b0;
  logic i_rst = 1'b1;
  logic [4:0] addr = 5'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rd_d = 1'b0;
  logic [15:0] wdata = 16'h0000;
  logic [15:0] rdata;
  pdr_events_t ev = '0;
  pdr_diag_t diag;
  pdr_diag_t plan = '0;
  logic done, pause = 1'b0, link = 1'b0, pol = 1'b0, start, int_pin;
  logic [15:0] exp_q[$];
  logic [15:0] dexp = 16'h0000;
  logic [7:0] en;
  int fails = 0;
  int checks_done = 0;
  always #2 i_clock = ~i_clock;
  pdr_regs dut (.i_clock(i_clock), .i_rst(i_rst), .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_rd(rd),
    .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_events(ev), .i_diag_done(done), .i_diag(diag),
    .i_pause_capable(pause), .i_link_up(link), .i_polarity_reversed(pol), .o_diag_start(start),
    .o_int_pin(int_pin));
  pdr_diag_model model (.i_clock(i_clock), .i_rst(i_rst), .i_start(start), .i_plan(plan), .o_done(done),
    .o_diag(diag));
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic acc(input logic [4:0] a, input logic w, input logic [15:0] d);
    @(posedge i_clock);
    addr <= a;
    wr <= w;
    rd <= !w;
    wdata <= d;
    @(posedge i_clock);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic rd_exp(input logic [4:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    acc(a, 1'b0, 16'h0000);
  endtask
  task automatic pulse(input logic [7:0] e);
    @(posedge i_clock);
    ev <= e;
    @(posedge i_clock);
    ev <= 8'h00;
    @(posedge i_clock);
    #1;
  endtask
  // Read data is registered on the read edge, so compare on the edge after that
  always @(posedge i_clock)
  begin
    if (rd_d)
      check("rdata", rdata, exp_q.pop_front());
    rd_d <= rd;
  end
  initial
  begin
    void'($urandom(32'h302b3d12));
    repeat (16) @(posedge i_clock);
    i_rst <= 1'b0;
    rd_exp(5'h1b, 16'h0000);
    rd_exp(5'h1d, 16'h0000);
    rd_exp(5'h1e, 16'h0000);
    check("int_idle", int_pin, 16'h0001);
    en = 8'($urandom());
    acc(5'h1b, 1'b1, {en, 8'hff});
    acc(5'h03, 1'b1, 16'hffff);
    rd_exp(5'h03, 16'h0000);
    rd_exp(5'h1b, {en, 8'h00});
    for (int i = 0; i < 8; i++)
    begin
      pulse(8'h01 << i);
      rd_exp(5'h1b, {en, 8'h01 << i});
      rd_exp(5'h1b, {en, 8'h00});
    end
    acc(5'h1b, 1'b1, 16'h0100);
    pulse(8'h80);
    check("int_masked", int_pin, 16'h0001);
    pulse(8'h01);
    check("int_low", int_pin, 16'h0000);
    acc(5'h1f, 1'b1, 16'h0200);
    #1;
    check("int_high", int_pin, 16'h0001);
    rd_exp(5'h1b, 16'h0181);
    #1;
    check("int_clear", int_pin, 16'h0000);
    // An event in the very cycle of a read must survive for the next read
    exp_q.push_back(16'h0100);
    @(posedge i_clock);
    ev <= 8'h04;
    addr <= 5'h1b;
    rd <= 1'b1;
    @(posedge i_clock);
    ev <= 8'h00;
    rd <= 1'b0;
    rd_exp(5'h1b, 16'h0104);
    // Every result code; read-only bits are written as ones and must not stick
    for (int c = 0; c < 4; c++)
    begin
      @(posedge i_clock);
      plan <= pdr_diag_t'({c[1:0], 10'($urandom())});
      acc(5'h1d, 1'b1, 16'hffff);
      rd_exp(5'h1d, {1'b1, dexp[14:0]});
      // A write clearing the start bit during the test must not abort it
      acc(5'h1d, 1'b1, 16'h0000);
      for (int k = 0; k < 40 && start !== 1'b0; k++)
        @(posedge i_clock);
      check("diag_done", start, 16'h0000);
      dexp = {1'b0, plan.result, plan.short_cable, 3'h0, plan.distance};
      rd_exp(5'h1d, dexp);
    end
    acc(5'h1e, 1'b1, 16'hffff);
    for (int i = 0; i < 4; i++)
    begin
      @(posedge i_clock);
      {pause, link, pol} <= 3'($urandom());
      repeat (3) @(posedge i_clock);
      rd_exp(5'h1e, {6'h00, pause, link, pol, 7'h00});
    end
    repeat (4) @(posedge i_clock);
    finish_test();
  end
  initial
  begin
    #200000;
    fails++;
    finish_test();
  end
endmodule
`default_nettype wire
